// >>> adcss_pkg.sv
/*
  Shared constants and types for the converter scan sequencer: register map,
  field positions, reset values and sequencer states.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package adcss_pkg;

  // register byte offsets
  localparam logic [7:0] ADCSS_OFS_CONVERTER_CONTROL = 8'h00;
  localparam logic [7:0] ADCSS_OFS_TRIGGER_INPUT_SELECT = 8'h04;
  localparam logic [7:0] ADCSS_OFS_FLAG_REGISTER = 8'h08;
  localparam logic [7:0] ADCSS_OFS_IRQ_ENABLE_REGISTER = 8'h0C;
  localparam logic [7:0] ADCSS_OFS_RESULT_BASE = 8'h10;
  localparam logic [7:0] ADCSS_OFS_RESULT_LAST = 8'h2C;

  // converter_control field positions
  localparam int ADCSS_CTL_BLOCK_ENABLE = 0;
  localparam int ADCSS_CTL_START = 1;
  localparam int ADCSS_CTL_CONVERTING = 10;
  localparam int ADCSS_CTL_INDEX_LSB = 12;

  // trigger_input_select field positions
  localparam int ADCSS_TRG_SAMPLE_LSB = 0;
  localparam int ADCSS_TRG_SOURCE_LSB = 4;
  localparam int ADCSS_TRG_REPEAT = 6;
  localparam int ADCSS_TRG_ALIGN = 7;
  localparam int ADCSS_TRG_FIRST_LSB = 8;
  localparam int ADCSS_TRG_LAST_LSB = 11;

  // reset values
  localparam logic [2:0] ADCSS_RST_SAMPLE_SEL = 3'h7;
  localparam logic [15:0] ADCSS_RST_ZERO16 = 16'h0000;

  // trigger_source_select codes
  localparam logic [1:0] ADCSS_SRC_SOFTWARE = 2'h0;
  localparam logic [1:0] ADCSS_SRC_TIMER = 2'h1;
  localparam logic [1:0] ADCSS_SRC_EXTERNAL = 2'h3;

  // sampling window is the select value plus this many clocks
  localparam logic [3:0] ADCSS_SAMPLE_BASE = 4'h4;
  localparam logic [2:0] ADCSS_TOP_INPUT = 3'h7;

  // bus answers
  localparam logic [1:0] ADCSS_RESP_OKAY = 2'h0;
  localparam logic [1:0] ADCSS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ADCSS_ST_IDLE = 2'b00,
    ADCSS_ST_SAMPLE = 2'b01,
    ADCSS_ST_CONVERT = 2'b10
  } adcss_state_t;

  // request toward the analog converter core
  typedef struct packed {
    logic sample;
    logic convert_go;
    logic [2:0] input_sel;
  } adcss_core_req_t;

endpackage

// >>> adcss_scan_sequencer.sv
/*
  Scan sequencer of a 12-bit successive-approximation converter channel with
  its AXI4-Lite register file, trigger selection, result store and flags.
  Assumes I_CLOCK is the shared timer operating clock, the timer underflow
  pulse is on that clock, the trigger pin is asynchronous, and the analog
  core answers a convert request with a one-cycle done pulse and its data.
*/
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - two-bit field picks trigger source
// - external mode: start arms, falling pin edge starts
// - timer mode: start arms, next underflow starts one scan; a one-time pass disarms
// - software mode: writing start begins immediately
// - triggers while converting are discarded
// - accepted trigger sets busy on next clock, sampling starts on the clock after
// - clearing start finishes current conversion, then halts
// - scan first to last input ascending
// - one-time mode stops after one pass
// - continuous mode rescans until start cleared
// - start stays set; rewrite 0 then 1
// - done flag set on load, write-1 clears
// - overwrite flag when done still set
// - overwrite error never stops the scan
// - interrupt only for enabled set flags
// - current index field shows converting input
// - after stop shows last input, top reads 0
// - converting flag is the busy indication
// - block enable gates operation, reads back
// - result low or high twelve bits
// - source codes 3 pin, 1 timer, 0 software
// - sampling window is select plus four
// - repeat select 1 continuous, 0 one-time
// - alignment applies at once to stored results
module adcss_scan_sequencer
  import adcss_pkg::*;
(
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  // axi4-lite write address and data
  input wire logic I_AXI_AWVALID,
  input wire logic [7:0] I_AXI_AWADDR,
  output logic O_AXI_AWREADY,
  input wire logic I_AXI_WVALID,
  input wire logic [31:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  output logic O_AXI_WREADY,
  // axi4-lite write response
  output logic O_AXI_BVALID,
  output logic [1:0] O_AXI_BRESP,
  input wire logic I_AXI_BREADY,
  // axi4-lite read
  input wire logic I_AXI_ARVALID,
  input wire logic [7:0] I_AXI_ARADDR,
  output logic O_AXI_ARREADY,
  output logic O_AXI_RVALID,
  output logic [31:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  input wire logic I_AXI_RREADY,
  // trigger sources
  input wire logic I_EXTERNAL_TRIGGER_N,
  input wire logic I_TIMER_UNDERFLOW,
  // analog converter core
  output adcss_core_req_t O_CORE_REQ,
  input wire logic I_CORE_DONE,
  input wire logic [11:0] I_CORE_DATA,
  // interrupt request
  output logic O_IRQ
);

  // ---------------- bus slave state ----------------
  logic aw_rdy_r, w_rdy_r, aw_hold_r, w_hold_r, bvalid_r;
  logic [1:0] bresp_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic ar_rdy_r, rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;

  // ---------------- register state ----------------
  logic block_enable_r, start_r, start_q_r;
  logic [15:0] trg_r;
  logic [7:0] done_flag_r, ovw_flag_r, done_ien_r, ovw_ien_r;
  logic [11:0] result_mem [0:7];
  logic irq_r;

  // ---------------- sequencer state ----------------
  adcss_state_t state_r, state_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [2:0] shown_idx_r, shown_idx_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic armed_r, armed_nxt;
  logic pend_r, pend_nxt;
  logic go_nxt;
  adcss_core_req_t core_r;

  // trigger pin synchroniser and filtered level
  logic ext_s1_r, ext_s2_r, ext_s3_r, ext_level_r;

  // field views of trigger_input_select
  wire [2:0] sample_cycles_select = trg_r[ADCSS_TRG_SAMPLE_LSB +: 3];
  wire [1:0] trigger_source_select = trg_r[ADCSS_TRG_SOURCE_LSB +: 2];
  wire repeat_mode_select = trg_r[ADCSS_TRG_REPEAT];
  wire result_alignment_select = trg_r[ADCSS_TRG_ALIGN];
  wire [2:0] first_input_select = trg_r[ADCSS_TRG_FIRST_LSB +: 3];
  wire [2:0] last_input_select = trg_r[ADCSS_TRG_LAST_LSB +: 3];

  // converting flag covers the pending start cycle too, so no trigger slips in
  wire converting_flag = pend_r | (state_r != ADCSS_ST_IDLE);

  // ---------------- write decode ----------------
  wire do_wr = aw_hold_r & w_hold_r & ~bvalid_r;
  wire [15:0] wmask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire [15:0] wbits = w_data_r[15:0] & wmask;
  wire wr_ctl = do_wr & (aw_addr_r == ADCSS_OFS_CONVERTER_CONTROL);
  wire wr_trg = do_wr & (aw_addr_r == ADCSS_OFS_TRIGGER_INPUT_SELECT);
  wire wr_intf = do_wr & (aw_addr_r == ADCSS_OFS_FLAG_REGISTER);
  wire wr_inte = do_wr & (aw_addr_r == ADCSS_OFS_IRQ_ENABLE_REGISTER);
  wire wr_res = do_wr & (aw_addr_r >= ADCSS_OFS_RESULT_BASE) &
                (aw_addr_r <= ADCSS_OFS_RESULT_LAST) & (aw_addr_r[1:0] == 2'h0);
  wire wr_ok = wr_ctl | wr_trg | wr_intf | wr_inte | wr_res;
  wire [15:0] trg_merged = (trg_r & ~wmask) | wbits;
  wire [15:0] inte_merged = ({ovw_ien_r, done_ien_r} & ~wmask) | wbits;
  wire [15:0] flag_clear = wr_intf ? wbits : ADCSS_RST_ZERO16;
  wire ctl_lane = wr_ctl & w_strb_r[0];

  // ---------------- read decode ----------------
  wire rd_take = I_AXI_ARVALID & ar_rdy_r;
  wire [7:0] ra = I_AXI_ARADDR;
  wire rd_res = (ra >= ADCSS_OFS_RESULT_BASE) & (ra <= ADCSS_OFS_RESULT_LAST) &
                (ra[1:0] == 2'h0);
  wire [7:0] res_ofs = ra - ADCSS_OFS_RESULT_BASE;
  wire [11:0] res_raw = result_mem[res_ofs[4:2]];
  // alignment is applied on the way out, so a change realigns every result at once
  wire [15:0] res_view = result_alignment_select ? {res_raw, 4'h0} : {4'h0, res_raw};
  wire [15:0] ctl_view = {1'b0, shown_idx_r, 1'b0, converting_flag, 8'h00,
                          start_r, block_enable_r};
  wire rd_ok = rd_res | (ra == ADCSS_OFS_CONVERTER_CONTROL) |
               (ra == ADCSS_OFS_TRIGGER_INPUT_SELECT) | (ra == ADCSS_OFS_FLAG_REGISTER) |
               (ra == ADCSS_OFS_IRQ_ENABLE_REGISTER);
  wire [15:0] rd_val = (ra == ADCSS_OFS_CONVERTER_CONTROL) ? ctl_view :
                       (ra == ADCSS_OFS_TRIGGER_INPUT_SELECT) ? trg_r :
                       (ra == ADCSS_OFS_FLAG_REGISTER) ? {ovw_flag_r, done_flag_r} :
                       (ra == ADCSS_OFS_IRQ_ENABLE_REGISTER) ? {ovw_ien_r, done_ien_r} :
                       rd_res ? res_view : ADCSS_RST_ZERO16;

  // ---------------- trigger selection ----------------
  wire start_rise = start_r & ~start_q_r;
  wire ext_fall = ext_level_r & (ext_s2_r == ext_s3_r) & ~ext_s2_r;
  wire sel_sw = trigger_source_select == ADCSS_SRC_SOFTWARE;
  wire sel_tmr = trigger_source_select == ADCSS_SRC_TIMER;
  wire sel_ext = trigger_source_select == ADCSS_SRC_EXTERNAL;
  wire trig_event = (sel_sw & start_rise) |
                    (sel_tmr & armed_r & I_TIMER_UNDERFLOW) |
                    (sel_ext & armed_r & ext_fall);
  wire trig_accept = trig_event & block_enable_r & ~converting_flag;
  wire [3:0] sample_len = {1'b0, sample_cycles_select} + ADCSS_SAMPLE_BASE;
  wire store = (state_r == ADCSS_ST_CONVERT) & I_CORE_DONE;
  wire keep_running = start_r & block_enable_r;

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    shown_idx_nxt = shown_idx_r;
    cnt_nxt = cnt_r;
    armed_nxt = armed_r;
    pend_nxt = 1'b0;
    go_nxt = 1'b0;
    // arming follows the start bit, so a stop needs 0 then 1 to rearm
    if (!start_r) begin
      armed_nxt = 1'b0;
    end else if (start_rise && !sel_sw) begin
      armed_nxt = 1'b1;
    end
    case (state_r)
      ADCSS_ST_IDLE: begin
        if (pend_r) begin
          state_nxt = ADCSS_ST_SAMPLE;
          idx_nxt = first_input_select;
          shown_idx_nxt = first_input_select;
          cnt_nxt = sample_len;
        end else if (trig_accept) begin
          pend_nxt = 1'b1;
        end
      end
      ADCSS_ST_SAMPLE: begin
        if (cnt_r == 4'h1) begin
          state_nxt = ADCSS_ST_CONVERT;
          go_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      ADCSS_ST_CONVERT: begin
        // an overwrite error has no say here: the scan goes on regardless
        if (store) begin
          if (!keep_running) begin
            state_nxt = ADCSS_ST_IDLE;
            shown_idx_nxt = (idx_r == ADCSS_TOP_INPUT) ? 3'h0 : idx_r;
          end else if (idx_r == last_input_select) begin
            if (repeat_mode_select) begin
              state_nxt = ADCSS_ST_SAMPLE;
              idx_nxt = first_input_select;
              shown_idx_nxt = first_input_select;
              cnt_nxt = sample_len;
            end else begin
              state_nxt = ADCSS_ST_IDLE;
              armed_nxt = 1'b0;
              shown_idx_nxt = (idx_r == ADCSS_TOP_INPUT) ? 3'h0 : idx_r;
            end
          end else begin
            state_nxt = ADCSS_ST_SAMPLE;
            idx_nxt = idx_r + 3'h1;
            shown_idx_nxt = idx_r + 3'h1;
            cnt_nxt = sample_len;
          end
        end
      end
      default: begin
        state_nxt = ADCSS_ST_IDLE;
      end
    endcase
  end

  // sequencer registers and core request
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      state_r <= ADCSS_ST_IDLE;
      idx_r <= 3'h0;
      shown_idx_r <= 3'h0;
      cnt_r <= 4'h0;
      armed_r <= 1'b0;
      pend_r <= 1'b0;
      core_r <= '0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      shown_idx_r <= shown_idx_nxt;
      cnt_r <= cnt_nxt;
      armed_r <= armed_nxt;
      pend_r <= pend_nxt;
      core_r.sample <= (state_nxt == ADCSS_ST_SAMPLE);
      core_r.convert_go <= go_nxt;
      core_r.input_sel <= idx_nxt;
    end
  end

  // trigger pin: three stages, a level counts once stages two and three agree
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
      ext_s3_r <= 1'b1;
      ext_level_r <= 1'b1;
    end else begin
      ext_s1_r <= I_EXTERNAL_TRIGGER_N;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      if (ext_s2_r == ext_s3_r) begin
        ext_level_r <= ext_s2_r;
      end
    end
  end

  // control and select registers; start is never cleared by hardware
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      block_enable_r <= 1'b0;
      start_r <= 1'b0;
      start_q_r <= 1'b0;
      trg_r <= {13'h0000, ADCSS_RST_SAMPLE_SEL};
      done_ien_r <= 8'h00;
      ovw_ien_r <= 8'h00;
    end else begin
      start_q_r <= start_r;
      if (ctl_lane) begin
        block_enable_r <= w_data_r[ADCSS_CTL_BLOCK_ENABLE];
        start_r <= w_data_r[ADCSS_CTL_START];
      end
      if (wr_trg) begin
        trg_r <= trg_merged & 16'h3FF7; // reserved bits stay zero
      end
      if (wr_inte) begin
        {ovw_ien_r, done_ien_r} <= inte_merged;
      end
    end
  end

  // per-input flags: a set in the clearing cycle wins over the clear
  genvar m;
  generate
    for (m = 0; m < 8; m = m + 1) begin : g_input
      wire hit = store & (idx_r == m[2:0]);
      always_ff @(posedge I_CLOCK or posedge I_RESET) begin
        if (I_RESET) begin
          done_flag_r[m] <= 1'b0;
          ovw_flag_r[m] <= 1'b0;
        end else begin
          done_flag_r[m] <= hit | (done_flag_r[m] & ~flag_clear[m]);
          ovw_flag_r[m] <= (hit & done_flag_r[m]) |
                           (ovw_flag_r[m] & ~flag_clear[m + 8]);
        end
      end
      // results are held raw; reset leaves them at zero
      always_ff @(posedge I_CLOCK or posedge I_RESET) begin
        if (I_RESET) begin
          result_mem[m] <= 12'h000;
        end else if (hit) begin
          result_mem[m] <= I_CORE_DATA;
        end
      end
    end
  endgenerate

  // one interrupt line from the enabled flags
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |({ovw_flag_r, done_flag_r} & {ovw_ien_r, done_ien_r});
    end
  end

  // write channels: address and data captured in either order
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      aw_rdy_r <= 1'b0;
      w_rdy_r <= 1'b0;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else begin
      if (I_AXI_AWVALID && aw_rdy_r) begin
        aw_rdy_r <= 1'b0;
        aw_hold_r <= 1'b1;
        aw_addr_r <= I_AXI_AWADDR;
      end else if (!aw_hold_r && !bvalid_r) begin
        aw_rdy_r <= 1'b1;
      end
      if (I_AXI_WVALID && w_rdy_r) begin
        w_rdy_r <= 1'b0;
        w_hold_r <= 1'b1;
        w_data_r <= I_AXI_WDATA;
        w_strb_r <= I_AXI_WSTRB;
      end else if (!w_hold_r && !bvalid_r) begin
        w_rdy_r <= 1'b1;
      end
      if (do_wr) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
      end
    end
  end

  // write response, unmapped addresses answer slverr
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      bvalid_r <= 1'b0;
      bresp_r <= ADCSS_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_ok ? ADCSS_RESP_OKAY : ADCSS_RESP_SLVERR;
    end else if (I_AXI_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  // read channel: data registered one cycle after the address is taken
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      ar_rdy_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= ADCSS_RESP_OKAY;
    end else begin
      if (rd_take) begin
        ar_rdy_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= {16'h0000, rd_val};
        rresp_r <= rd_ok ? ADCSS_RESP_OKAY : ADCSS_RESP_SLVERR;
      end else if (rvalid_r && I_AXI_RREADY) begin
        rvalid_r <= 1'b0;
      end else if (!rvalid_r && !ar_rdy_r) begin
        ar_rdy_r <= 1'b1;
      end
    end
  end

  // outputs straight from flip-flops
  assign O_AXI_AWREADY = aw_rdy_r;
  assign O_AXI_WREADY = w_rdy_r;
  assign O_AXI_BVALID = bvalid_r;
  assign O_AXI_BRESP = bresp_r;
  assign O_AXI_ARREADY = ar_rdy_r;
  assign O_AXI_RVALID = rvalid_r;
  assign O_AXI_RDATA = rdata_r;
  assign O_AXI_RRESP = rresp_r;
  assign O_CORE_REQ = core_r;
  assign O_IRQ = irq_r;

endmodule

`default_nettype wire

// >>> adcss_chk.sv
/*
  Port checker for the scan sequencer: bus holds, sampling window, core pulses, irq cause.
  Assumes one clock domain and an async high reset that clears every output.
*/
`timescale 1ns/1ps
`default_nettype none
module adcss_chk
  import adcss_pkg::*;
(
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  // bus answers
  input wire logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  input wire logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  // core side and interrupt
  input wire adcss_core_req_t O_CORE_REQ,
  input wire logic I_CORE_DONE,
  input wire logic O_IRQ
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RESET);

  // steps of one conversion: shortest window, then the go pulse
  sequence s_win;
    O_CORE_REQ.sample [*4];
  endsequence
  sequence s_go;
    O_CORE_REQ.convert_go;
  endsequence

  property p_win_min;
    $rose(O_CORE_REQ.sample) |-> s_win;
  endproperty
  property p_win_max;
    $rose(O_CORE_REQ.sample) |-> ##[1:11] !O_CORE_REQ.sample;
  endproperty
  property p_go_after;
    s_go |-> $past(O_CORE_REQ.sample);
  endproperty
  property p_go_pulse;
    s_go |=> !O_CORE_REQ.convert_go;
  endproperty
  // no new sampling in the cycle right after the go pulse
  property p_no_samp;
    s_go |=> !O_CORE_REQ.sample;
  endproperty
  property p_sel_hold;
    O_CORE_REQ.sample && $past(O_CORE_REQ.sample) |-> $stable(O_CORE_REQ.input_sel);
  endproperty
  property p_b_hold;
    O_AXI_BVALID && !I_AXI_BREADY |=> O_AXI_BVALID;
  endproperty
  property p_r_hold;
    O_AXI_RVALID && !I_AXI_RREADY |=> O_AXI_RVALID;
  endproperty
  // irq only rises after a result load or a register write
  property p_irq_cause;
    $rose(O_IRQ) |-> $past(I_CORE_DONE) || $past(I_CORE_DONE, 2)
      || $past(O_AXI_BVALID) || $past(O_AXI_BVALID, 2);
  endproperty

  a_win_min: assert property (p_win_min) else $error("window short");
  a_win_max: assert property (p_win_max) else $error("window long");
  a_go_after: assert property (p_go_after) else $error("go without sample");
  a_go_pulse: assert property (p_go_pulse) else $error("go too long");
  a_no_samp: assert property (p_no_samp) else $error("sample during convert");
  a_sel_hold: assert property (p_sel_hold) else $error("input moved");
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
endmodule

bind adcss_scan_sequencer adcss_chk adcss_chk_inst (
  .I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .O_AXI_BVALID(O_AXI_BVALID),
  .I_AXI_BREADY(I_AXI_BREADY), .O_AXI_RVALID(O_AXI_RVALID), .I_AXI_RREADY(I_AXI_RREADY),
  .O_CORE_REQ(O_CORE_REQ), .I_CORE_DONE(I_CORE_DONE), .O_IRQ(O_IRQ)
);
`default_nettype wire

// >>> adcss_core_mdl.sv
/*
  Behavioural analog core: answers each convert pulse with a done pulse and data.
  Assumes the sequencer holds input_sel steady until done.
*/
`timescale 1ns/1ps
`default_nettype none
module adcss_core_mdl
  import adcss_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // request and answer
  input wire adcss_core_req_t i_req,
  output logic o_done,
  output logic [11:0] o_data
);
  logic [2:0] cnt_r;
  logic slow_r;
  logic busy_r;
  // alternates fast and slow answers; data toggles when not valid so stale data never matches
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      cnt_r <= 3'h0;
      slow_r <= 1'b0;
      busy_r <= 1'b0;
      o_done <= 1'b0;
      o_data <= 12'h000;
    end else begin
      o_done <= 1'b0;
      o_data <= ~o_data;
      if (i_req.convert_go) begin
        busy_r <= 1'b1;
        cnt_r <= slow_r ? 3'h5 : 3'h1;
        slow_r <= ~slow_r;
      end else if (busy_r && cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
      end else if (busy_r) begin
        busy_r <= 1'b0;
        o_done <= 1'b1;
        o_data <= {1'b1, i_req.input_sel, 8'hA5};
      end
    end
  end
endmodule
`default_nettype wire

// >>> adcss_scan_sequencer_tb.sv
/*
  Self-checking bench for the scan sequencer: table of software scans, then alignment, overwrite, irq,
  trigger sources, continuous stop, unmapped access and a second reset.
  Assumes the core model answers with {1, input, A5} in the low twelve bits.
*/
`timescale 1ns/1ps
`default_nettype none
module adcss_scan_sequencer_tb
  import adcss_pkg::*;
;
  typedef struct packed {logic [2:0] f; logic [2:0] l; logic [2:0] s; logic a;} adcss_row_t;
  localparam logic [7:0] A_CTL = ADCSS_OFS_CONVERTER_CONTROL;
  localparam logic [7:0] A_TRG = ADCSS_OFS_TRIGGER_INPUT_SELECT;
  localparam logic [7:0] A_FLG = ADCSS_OFS_FLAG_REGISTER;
  localparam logic [7:0] A_IE = ADCSS_OFS_IRQ_ENABLE_REGISTER;
  localparam logic [7:0] A_RES = ADCSS_OFS_RESULT_BASE;
  logic clk, rst, awv, wv, br, arv, rr, ext_n, tu;
  logic awrdy, wrdy, bv, arrdy, rv, cdone, irq;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, got;
  logic [1:0] bresp, rresp, resp;
  logic [11:0] cdata;
  adcss_core_req_t req;
  int err_total, comparisons, i;
  adcss_row_t rows [4] = '{'{3'h0, 3'h7, 3'h0, 1'b0}, '{3'h2, 3'h5, 3'h7, 1'b1},
    '{3'h3, 3'h3, 3'h3, 1'b0}, '{3'h5, 3'h5, 3'h7, 1'b1}};

  adcss_scan_sequencer adcss_scan_sequencer_inst (
    .I_CLOCK(clk), .I_RESET(rst), .I_AXI_AWVALID(awv), .I_AXI_AWADDR(awa),
    .O_AXI_AWREADY(awrdy), .I_AXI_WVALID(wv), .I_AXI_WDATA(wd), .I_AXI_WSTRB(4'hF),
    .O_AXI_WREADY(wrdy), .O_AXI_BVALID(bv), .O_AXI_BRESP(bresp), .I_AXI_BREADY(br),
    .I_AXI_ARVALID(arv), .I_AXI_ARADDR(ara), .O_AXI_ARREADY(arrdy), .O_AXI_RVALID(rv),
    .O_AXI_RDATA(rdat), .O_AXI_RRESP(rresp), .I_AXI_RREADY(rr),
    .I_EXTERNAL_TRIGGER_N(ext_n), .I_TIMER_UNDERFLOW(tu), .O_CORE_REQ(req),
    .I_CORE_DONE(cdone), .I_CORE_DATA(cdata), .O_IRQ(irq)
  );
  adcss_core_mdl adcss_core_mdl_inst (
    .i_clock(clk), .i_reset(rst), .i_req(req), .o_done(cdone), .o_data(cdata)
  );

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("counts: %0d mismatches, %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tmo();
    err_total++;
    $display("mismatch at %0t: wait ran out", $time);
    report_and_stop();
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    br <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv === 1'b1) break;
    end
    br <= 1'b0;
    resp = bresp;
    if (k == 40) tmo();
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (arrdy) arv <= 1'b0;
      if (rv === 1'b1) break;
    end
    rr <= 1'b0;
    got = rdat;
    resp = rresp;
    if (k == 40) tmo();
  endtask
  // poll the converting flag; the bus is the only view of busy
  task automatic wait_busy(input logic v);
    int k;
    for (k = 0; k < 200; k++) begin
      rd(A_CTL);
      if (got[ADCSS_CTL_CONVERTING] === v) break;
    end
    if (k == 200) tmo();
  endtask
  // start goes 0 then 1; each write spans several clocks, so holds are met
  task automatic start_sw();
    wr(A_CTL, 32'h1);
    wr(A_CTL, 32'h3);
  endtask
  function automatic logic [31:0] res(input logic [2:0] m, input logic a);
    res = a ? {16'h0, 1'b1, m, 8'hA5, 4'h0} : {20'h0, 1'b1, m, 8'hA5};
  endfunction
  function automatic logic [31:0] trg(input logic [2:0] f, l, s, input logic a, r,
                                      input logic [1:0] c);
    trg = {18'h0, l, f, a, r, c, 1'b0, s};
  endfunction
  function automatic logic [31:0] msk(input logic [2:0] f, l);
    msk = 32'h0;
    for (int m = f; m <= l; m++) msk[m] = 1'b1;
  endfunction

  // main sequence
  initial begin
    rst = 1'b1;
    {awv, wv, br, arv, rr, tu, awa, ara, wd} = '0;
    ext_n = 1'b1;
    err_total = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) begin
      wr(A_TRG, trg(rows[i].f, rows[i].l, rows[i].s, rows[i].a, 1'b0, ADCSS_SRC_SOFTWARE));
      wr(A_FLG, 32'hFFFF);
      start_sw();
      wait_busy(1'b0);
      rd(A_FLG);
      chk(got, msk(rows[i].f, rows[i].l));
      rd(A_RES + {3'h0, rows[i].f, 2'h0});
      chk(got, res(rows[i].f, rows[i].a));
      rd(A_RES + {3'h0, rows[i].l, 2'h0});
      chk(got, res(rows[i].l, rows[i].a));
      rd(A_CTL);
      chk(got, {17'h0, (rows[i].l == 3'h7) ? 3'h0 : rows[i].l, 12'h003});
    end
    // flip alignment under a stored result
    wr(A_TRG, trg(3'h5, 3'h5, 3'h7, 1'b0, 1'b0, ADCSS_SRC_SOFTWARE));
    rd(A_RES + 8'h14);
    chk(got, res(3'h5, 1'b0));
    wr(A_CTL, 32'h3);
    rd(A_CTL);
    chk(got, 32'h5003);
    // done flag set but only the overwrite irq of input 5 enabled
    wr(A_IE, 32'h2000);
    rd(A_IE);
    chk(got, 32'h2000);
    chk({31'h0, irq}, 32'h0);
    wr(A_TRG, trg(3'h5, 3'h6, 3'h0, 1'b0, 1'b0, ADCSS_SRC_SOFTWARE));
    start_sw();
    wait_busy(1'b0);
    rd(A_FLG);
    chk(got, 32'h2060);
    chk({31'h0, irq}, 32'h1);
    wr(A_FLG, 32'h2000);
    rd(A_FLG);
    chk(got, 32'h0060);
    chk({31'h0, irq}, 32'h0);
    // timer source: start only arms, underflow launches
    wr(A_FLG, 32'hFFFF);
    wr(A_TRG, trg(3'h1, 3'h2, 3'h0, 1'b0, 1'b0, ADCSS_SRC_TIMER));
    start_sw();
    rd(A_CTL);
    chk(got & 32'h0400, 32'h0);
    @(posedge clk);
    tu <= 1'b1;
    @(posedge clk);
    tu <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    rd(A_FLG);
    chk(got, 32'h0006);
    // external pin: start arms, falling edge launches
    wr(A_FLG, 32'hFFFF);
    wr(A_TRG, trg(3'h3, 3'h3, 3'h0, 1'b0, 1'b0, ADCSS_SRC_EXTERNAL));
    start_sw();
    rd(A_CTL);
    chk(got & 32'h0400, 32'h0);
    ext_n <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    ext_n <= 1'b1;
    rd(A_FLG);
    chk(got, 32'h0008);
    // continuous scan, then clear start and let it finish
    wr(A_FLG, 32'hFFFF);
    wr(A_TRG, trg(3'h0, 3'h1, 3'h0, 1'b0, 1'b1, ADCSS_SRC_SOFTWARE));
    start_sw();
    repeat (150) @(posedge clk);
    wr(A_CTL, 32'h1);
    wait_busy(1'b0);
    rd(A_FLG);
    chk(got, 32'h0303);
    wr(A_CTL, 32'h2);
    rd(A_CTL);
    chk(got & 32'h0FFF, 32'h0002);
    // unmapped place
    wr(8'h30, 32'h1);
    chk({30'h0, resp}, {30'h0, ADCSS_RESP_SLVERR});
    rd(8'h30);
    chk({30'h0, resp}, {30'h0, ADCSS_RESP_SLVERR});
    chk(got, 32'h0);
    // second reset restores the reset values of the first four registers
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) begin
      rd({i[5:0], 2'h0});
      chk(got, (i == 1) ? 32'h0007 : 32'h0);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
